/* File: hw/fp_add.sv */
`timescale 1ns/1ps
module fp_add
   import valu_pkg::*;
(
   // Operands.
   input wire logic [31:0] a,
   input wire logic [31:0] b,
   // Rounded sum.
   output logic [31:0] sum
);
   logic swap;
   logic [31:0] x;
   logic [31:0] y;
   logic [7:0] ex;
   logic [7:0] ey;
   logic [7:0] dd;
   logic [47:0] mx;
   logic [47:0] yj;
   logic [47:0] r;
   logic [95:0] sh;
   logic same;

   // The larger magnitude goes to x so that only y is aligned.
   assign swap = a[30:0] < b[30:0];
   assign x = swap ? b : a;
   assign y = swap ? a : b;
   assign ex = x[30:23] | {7'h0, ~|x[30:23]};
   assign ey = y[30:23] | {7'h0, ~|y[30:23]};
   assign dd = (ex - ey > SHIFT_CLAMP) ? SHIFT_CLAMP : ex - ey;
   assign mx = {1'b0, |x[30:23], x[22:0], 23'h0};
   assign sh = {1'b0, |y[30:23], y[22:0], 23'h0, 48'h0} >> dd;
   // Bits shifted out are jammed into the lowest bit so rounding stays exact.
   assign yj = sh[95:48] | {47'h0, |sh[47:0]};
   assign same = x[31] == y[31];
   assign r = same ? mx + yj : mx - yj;

   // Exact cancellation gives plus zero under round to nearest.
   always_comb begin
      if (is_nan(a)) begin
         sum = quiet(a);
      end else if (is_nan(b)) begin
         sum = quiet(b);
      end else if (is_inf(x)) begin
         sum = (is_inf(y) && !same) ? F32_QNAN : x;
      end else begin
         sum = round_pack((r == 48'h0 && !same) ? 1'b0 : x[31], $signed({4'h0, ex}), r);
      end
   end
endmodule

/* File: hw/fp_mul.sv */
`timescale 1ns/1ps
module fp_mul
   import valu_pkg::*;
(
   // Operands and integer mode.
   input wire logic [31:0] a,
   input wire logic [31:0] b,
   input wire logic int_mode,
   input wire logic int_signed,
   // Raw array product and rounded float result.
   output logic [47:0] product,
   output logic [31:0] result
);
   logic [24:0] oa;
   logic [24:0] ob;
   logic signed [49:0] full;
   logic signed [11:0] e;

   // One 25-bit signed array serves both the float significands and the 24-bit integers.
   assign oa = int_mode ? {int_signed & a[23], a[23:0]} : {1'b0, |a[30:23], a[22:0]};
   assign ob = int_mode ? {int_signed & b[23], b[23:0]} : {1'b0, |b[30:23], b[22:0]};
   assign full = $signed(oa) * $signed(ob);
   assign product = full[47:0];
   assign e = $signed({4'h0, a[30:23] | {7'h0, ~|a[30:23]}})
      + $signed({4'h0, b[30:23] | {7'h0, ~|b[30:23]}}) - EXP_BIAS;

   // Special operands first, then normalise and round the exact product.
   always_comb begin
      if (is_nan(a)) begin
         result = quiet(a);
      end else if (is_nan(b)) begin
         result = quiet(b);
      end else if ((is_inf(a) && is_zero(b)) || (is_inf(b) && is_zero(a))) begin
         result = F32_QNAN;
      end else if (is_inf(a) || is_inf(b)) begin
         result = {a[31] ^ b[31], EXP_ALL_ONES, 23'h0};
      end else begin
         result = round_pack(a[31] ^ b[31], e, product);
      end
   end
endmodule

/* File: hw/valu_pkg.sv */
package valu_pkg;
   localparam logic [5:0] OP_COND_SELECT = 6'h01;
   localparam logic [5:0] OP_HALF_DOT = 6'h02;
   localparam logic [5:0] OP_FADD = 6'h03;
   localparam logic [5:0] OP_FSUB = 6'h04;
   localparam logic [5:0] OP_FRSUB = 6'h05;
   localparam logic [5:0] OP_LEG_MAC = 6'h06;
   localparam logic [5:0] OP_LEG_MUL = 6'h07;
   localparam logic [5:0] OP_FMUL = 6'h08;
   localparam logic [5:0] OP_SMUL_LO = 6'h09;
   localparam logic [5:0] OP_SMUL_HI = 6'h0a;
   localparam logic [5:0] OP_UMUL_LO = 6'h0b;
   localparam logic [5:0] OP_UMUL_HI = 6'h0c;
   localparam logic [5:0] OP_BYTE_DOT = 6'h0d;
   localparam logic [5:0] OP_HOLE = 6'h0e;
   localparam logic [5:0] OP_FMIN = 6'h0f;
   localparam logic [5:0] OP_FMAX = 6'h10;
   localparam logic [5:0] OP_IMIN = 6'h11;
   localparam logic [5:0] OP_IMAX = 6'h12;
   localparam logic [5:0] OP_UMIN = 6'h13;
   localparam logic [5:0] OP_UMAX = 6'h14;
   localparam logic [1:0] XW_NONE = 2'h0;
   localparam logic [1:0] XW_LITERAL = 2'h1;
   localparam logic [1:0] XW_PERMUTE = 2'h2;
   localparam logic [1:0] XW_SUBWORD = 2'h3;
   localparam logic [31:0] RESULT_RESET = 32'h0;
   localparam logic [31:0] F32_QNAN = 32'h7fc00000;
   localparam logic [31:0] F32_ZERO = 32'h00000000;
   localparam logic [31:0] F32_NEG_ZERO = 32'h80000000;
   localparam logic [7:0] EXP_ALL_ONES = 8'hff;
   localparam logic signed [11:0] EXP_BIAS = 12'sd127;
   localparam logic signed [11:0] F16_REBIAS = 12'sd112;
   localparam logic [7:0] SHIFT_CLAMP = 8'd60;

   function automatic logic is_nan(input logic [31:0] v);
      return v[30:23] == EXP_ALL_ONES && v[22:0] != 23'h0;
   endfunction

   function automatic logic is_snan(input logic [31:0] v);
      return is_nan(v) && !v[22];
   endfunction

   function automatic logic is_inf(input logic [31:0] v);
      return v[30:23] == EXP_ALL_ONES && v[22:0] == 23'h0;
   endfunction

   function automatic logic is_zero(input logic [31:0] v);
      return v[30:0] == 31'h0;
   endfunction

   function automatic logic [31:0] quiet(input logic [31:0] v);
      return {v[31:23], 1'b1, v[21:0]};
   endfunction

   // Normalises m (binary point after bit 46, scale 2^(e-127)) and rounds to nearest even.
   function automatic logic [31:0] round_pack(input logic sgn, input logic signed [11:0] e,
                                              input logic [47:0] m);
      logic [5:0] lz;
      logic [47:0] mn;
      logic [47:0] mr;
      logic signed [11:0] en;
      logic [11:0] amt;
      logic [95:0] sh;
      logic st;
      logic up;
      logic [7:0] ef;
      logic [30:0] body;
      lz = 6'd0;
      for (int k = 0; k < 48; k++) begin
         if (m[k]) begin
            lz = 6'(47 - k);
         end
      end
      mn = m << lz;
      en = e + 12'sd1 - $signed({6'h0, lz});
      mr = mn;
      st = 1'b0;
      ef = 8'h00;
      if (en <= 12'sd0) begin
         amt = 12'(12'sd1 - en);
         if (amt > 12'd48) begin
            amt = 12'd48;
         end
         sh = {mn, 48'h0} >> amt;
         mr = sh[95:48];
         st = |sh[47:0];
      end else begin
         ef = en[7:0];
      end
      up = mr[23] & (st | (|mr[22:0]) | mr[24]);
      body = {ef, mr[46:24]} + {30'h0, up};
      if (m == 48'h0) begin
         return {sgn, 31'h0};
      end
      if (en >= $signed({4'h0, EXP_ALL_ONES})) begin
         return {sgn, EXP_ALL_ONES, 23'h0};
      end
      return {sgn, body};
   endfunction
endpackage

/* File: hw/vector_two_operand_alu.sv */
`timescale 1ns/1ps
module vector_two_operand_alu
   import valu_pkg::*;
#(
   parameter int LANES = 32
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_b,
   // Instruction issue.
   input wire logic issue_valid,
   input wire logic [5:0] opcode,
   input wire logic ieee_mode,
   input wire logic three_src_form,
   input wire logic [1:0] abs_mod,
   input wire logic [1:0] neg_mod,
   // Extra word after the instruction.
   input wire logic [1:0] extra_kind,
   input wire logic [31:0] extra_word,
   // Lane masks.
   input wire logic [LANES-1:0] exec_mask,
   input wire logic [LANES-1:0] cond_mask,
   input wire logic [LANES-1:0] scalar_mask,
   // Lane operands.
   input wire logic [LANES*32-1:0] src0,
   input wire logic [LANES*32-1:0] src1,
   input wire logic [LANES*32-1:0] dst_in,
   // Write-back.
   output logic result_valid,
   output logic opcode_illegal,
   output logic [LANES-1:0] result_lane_we,
   output logic [LANES*32-1:0] result_data
);
   logic op_legal;
   logic is_fp32;
   logic is_imul;
   logic imul_signed;
   logic valid_q;
   logic illegal_q;
   logic [LANES-1:0] we_q;

   // Applies the absolute and negate modifiers to a float operand.
   function automatic logic [31:0] fmod(input logic [31:0] v, input logic ab, input logic ng);
      return {(v[31] & ~ab) ^ ng, v[30:0]};
   endfunction

   // Picks a byte or half word of v, zero extended, or the whole word.
   function automatic logic [31:0] subword(input logic [31:0] v, input logic [2:0] s);
      if (s < 3'd4) begin
         return {24'h0, v[8*s[1:0] +: 8]};
      end
      if (s < 3'd6) begin
         return {16'h0, v[16*s[0] +: 16]};
      end
      return v;
   endfunction

   // Widens a half-precision value exactly, denormals included.
   function automatic logic [31:0] h2f(input logic [15:0] h);
      if (h[14:10] == 5'h1f) begin
         return {h[15], EXP_ALL_ONES, h[9:0], 13'h0};
      end
      return round_pack(h[15], $signed({7'h0, h[14:10] | {4'h0, ~|h[14:10]}}) + F16_REBIAS,
                        {1'b0, |h[14:10], h[9:0], 36'h0});
   endfunction

   // Strict less-than for two non-NaN floats that are not a pair of zeros.
   function automatic logic flt(input logic [31:0] x, input logic [31:0] y);
      if (x[31] != y[31]) begin
         return x[31];
      end
      return x[31] ? (x[30:0] > y[30:0]) : (x[30:0] < y[30:0]);
   endfunction

   // Float minimum with its NaN and signed-zero order.
   function automatic logic [31:0] fmin(input logic [31:0] x, input logic [31:0] y,
                                        input logic ieee);
      if (ieee && is_snan(x)) begin
         return quiet(x);
      end
      if (ieee && is_snan(y)) begin
         return quiet(y);
      end
      if (is_nan(x)) begin
         return y;
      end
      if (is_nan(y)) begin
         return x;
      end
      if (is_zero(x) && is_zero(y)) begin
         return x[31] ? x : y;
      end
      return flt(x, y) ? x : y;
   endfunction

   // Float maximum; IEEE mode keeps x on a tie.
   function automatic logic [31:0] fmax(input logic [31:0] x, input logic [31:0] y,
                                        input logic ieee);
      if (ieee && is_snan(x)) begin
         return quiet(x);
      end
      if (ieee && is_snan(y)) begin
         return quiet(y);
      end
      if (is_nan(x)) begin
         return y;
      end
      if (is_nan(y)) begin
         return x;
      end
      if (is_zero(x) && is_zero(y)) begin
         return x[31] ? y : x;
      end
      if (ieee) begin
         return flt(x, y) ? y : x;
      end
      return flt(y, x) ? x : y;
   endfunction

   // Opcode classes shared by every lane.
   assign is_imul = opcode >= OP_SMUL_LO && opcode <= OP_UMUL_HI;
   assign imul_signed = opcode == OP_SMUL_LO || opcode == OP_SMUL_HI;
   assign is_fp32 = opcode == OP_COND_SELECT || (opcode >= OP_FADD && opcode <= OP_FMUL)
      || opcode == OP_FMIN || opcode == OP_FMAX;
   assign op_legal = opcode >= OP_COND_SELECT && opcode <= OP_UMAX && opcode != OP_HOLE;

   for (genvar l = 0; l < LANES; l++) begin : g_lane
      localparam int QB = (l / 4) * 4;
      logic [1:0] perm;
      logic [31:0] a_raw;
      logic [31:0] b;
      logic [31:0] d;
      logic [31:0] fa;
      logic [31:0] fb;
      logic [31:0] prod;
      logic [31:0] leg_prod;
      logic [31:0] p0;
      logic [31:0] p1;
      logic [31:0] hsum;
      logic [31:0] add_x;
      logic [31:0] add_y;
      logic [31:0] sum;
      logic [31:0] bdot;
      logic [31:0] res;
      logic [31:0] res_q;
      logic [47:0] iprod;
      logic cmask;

      assign perm = extra_word[2*(l%4) +: 2];

      // The extra word stands in for source one in one of three ways.
      always_comb begin
         case (extra_kind)
            XW_LITERAL: a_raw = extra_word;
            XW_PERMUTE: a_raw = src0[(QB + perm)*32 +: 32];
            XW_SUBWORD: a_raw = subword(src0[l*32 +: 32], extra_word[2:0]);
            default: a_raw = src0[l*32 +: 32];
         endcase
      end

      // Float modifiers touch only the 32-bit float operations.
      assign b = src1[l*32 +: 32];
      assign d = dst_in[l*32 +: 32];
      assign fa = is_fp32 ? fmod(a_raw, abs_mod[0], neg_mod[0]) : a_raw;
      assign fb = is_fp32 ? fmod(b, abs_mod[1], neg_mod[1]) : b;
      assign cmask = three_src_form ? scalar_mask[l] : cond_mask[l];

      // Main multiplier, also the narrow integer multiplier.
      fp_mul u_mul (
         .a(fa),
         .b(fb),
         .int_mode(is_imul),
         .int_signed(imul_signed),
         .product(iprod),
         .result(prod)
      );

      // Half products are exact in single precision.
      fp_mul u_mul_lo (
         .a(h2f(a_raw[15:0])),
         .b(h2f(b[15:0])),
         .int_mode(1'b0),
         .int_signed(1'b0),
         .product(),
         .result(p0)
      );

      fp_mul u_mul_hi (
         .a(h2f(a_raw[31:16])),
         .b(h2f(b[31:16])),
         .int_mode(1'b0),
         .int_signed(1'b0),
         .product(),
         .result(p1)
      );

      fp_add u_hsum (
         .a(p0),
         .b(p1),
         .sum(hsum)
      );

      // A zero factor wins over infinity and NaN in the legacy multiplies.
      assign leg_prod = (is_zero(fa) || is_zero(fb)) ? F32_ZERO : prod;

      // Operand routing for the shared adder.
      always_comb begin
         add_x = fa;
         add_y = fb;
         case (opcode)
            OP_FSUB: add_y = {~fb[31], fb[30:0]};
            OP_FRSUB: begin
               add_x = fb;
               add_y = {~fa[31], fa[30:0]};
            end
            OP_LEG_MAC: begin
               add_x = leg_prod;
               add_y = d;
            end
            OP_HALF_DOT: begin
               add_x = hsum;
               add_y = d;
            end
            default: begin
            end
         endcase
      end

      fp_add u_add (
         .a(add_x),
         .b(add_y),
         .sum(sum)
      );

      // Four signed byte products summed onto the destination, wrapping at 32 bits.
      always_comb begin
         logic signed [15:0] pk;
         pk = 16'sh0;
         bdot = d;
         for (int k = 0; k < 4; k++) begin
            pk = $signed(a_raw[8*k +: 8]) * $signed(b[8*k +: 8]);
            bdot = bdot + 32'(pk);
         end
      end

      // Result selection by opcode.
      always_comb begin
         case (opcode)
            OP_COND_SELECT: res = cmask ? fb : fa;
            OP_HALF_DOT, OP_FADD, OP_FSUB, OP_FRSUB, OP_LEG_MAC: res = sum;
            OP_LEG_MUL: res = leg_prod;
            OP_FMUL: res = prod;
            OP_SMUL_LO: res = iprod[31:0];
            OP_UMUL_LO: res = iprod[31:0];
            OP_SMUL_HI: res = {{16{iprod[47]}}, iprod[47:32]};
            OP_UMUL_HI: res = {16'h0, iprod[47:32]};
            OP_BYTE_DOT: res = bdot;
            OP_FMIN: res = fmin(fa, fb, ieee_mode);
            OP_FMAX: res = fmax(fa, fb, ieee_mode);
            OP_IMIN: res = ($signed(a_raw) < $signed(b)) ? a_raw : b;
            OP_IMAX: res = ($signed(a_raw) >= $signed(b)) ? a_raw : b;
            OP_UMIN: res = (a_raw < b) ? a_raw : b;
            OP_UMAX: res = (a_raw >= b) ? a_raw : b;
            default: res = d;
         endcase
      end

      // A lane result is stored only when the lane is enabled.
      always_ff @(posedge sys_clk or negedge rst_b) begin
         if (!rst_b) begin
            res_q <= RESULT_RESET;
         end else if (issue_valid && op_legal && exec_mask[l]) begin
            res_q <= res;
         end
      end

      assign result_data[l*32 +: 32] = res_q;
   end

   // Write-back strobes follow the issue by one cycle.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         valid_q <= 1'b0;
         illegal_q <= 1'b0;
         we_q <= '0;
      end else begin
         valid_q <= issue_valid && op_legal;
         illegal_q <= issue_valid && !op_legal;
         we_q <= (issue_valid && op_legal) ? exec_mask : '0;
      end
   end

   assign result_valid = valid_q;
   assign opcode_illegal = illegal_q;
   assign result_lane_we = we_q;

   // Lane 0 views used by the checks below.
   logic chk0;
   logic [31:0] a0;
   logic [31:0] b0;
   logic signed [47:0] sp0;
   logic [47:0] up0;
   assign a0 = src0[31:0];
   assign b0 = src1[31:0];
   assign chk0 = issue_valid && exec_mask[0] && extra_kind == XW_NONE
      && abs_mod == 2'b00 && neg_mod == 2'b00;
   assign sp0 = $signed(a0[23:0]) * $signed(b0[23:0]);
   assign up0 = a0[23:0] * b0[23:0];

   cond_select_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      chk0 && opcode == OP_COND_SELECT && three_src_form && scalar_mask[0]
      |=> result_lane_we[0] && result_data[31:0] == $past(b0))
      else $error("Select did not follow the scalar mask.");

   denorm_add_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      chk0 && opcode == OP_FADD && a0 == 32'h00000001 && b0 == 32'h00000001
      |=> result_data[31:0] == 32'h00000002)
      else $error("Denormal add was flushed or wrong.");

   legacy_zero_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      chk0 && opcode == OP_LEG_MUL && a0 == F32_ZERO
      |=> result_data[31:0] == F32_ZERO)
      else $error("Legacy zero product not zero.");

   smul_low_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      chk0 && opcode == OP_SMUL_LO |=> result_data[31:0] == $past(sp0[31:0]))
      else $error("Signed narrow low product wrong.");

   smul_high_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      chk0 && opcode == OP_SMUL_HI
      |=> result_data[31:0] == {{16{$past(sp0[47])}}, $past(sp0[47:32])})
      else $error("Signed narrow high product wrong.");

   umul_high_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      chk0 && opcode == OP_UMUL_HI |=> result_data[31:0] == {16'h0, $past(up0[47:32])})
      else $error("Unsigned narrow high product wrong.");

   fmin_zero_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      chk0 && opcode == OP_FMIN && a0 == F32_ZERO && b0 == F32_NEG_ZERO
      |=> result_data[31:0] == F32_NEG_ZERO)
      else $error("Minimum of signed zeros not minus zero.");

   fmax_zero_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      chk0 && opcode == OP_FMAX && a0 == F32_NEG_ZERO && b0 == F32_ZERO
      |=> result_data[31:0] == F32_ZERO)
      else $error("Maximum of signed zeros not plus zero.");

   imax_tie_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      chk0 && opcode == OP_IMAX
      |=> result_data[31:0] == (($signed($past(a0)) >= $signed($past(b0))) ? $past(a0)
                                                                           : $past(b0)))
      else $error("Signed maximum wrong.");

   umin_word_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      chk0 && opcode == OP_UMIN
      |=> result_data[31:0] == (($past(a0) < $past(b0)) ? $past(a0) : $past(b0)))
      else $error("Unsigned minimum wrong.");

   literal_word_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      issue_valid && exec_mask[0] && extra_kind == XW_LITERAL && opcode == OP_UMAX
      |=> result_data[31:0] == (($past(extra_word) >= $past(b0)) ? $past(extra_word)
                                                                 : $past(b0)))
      else $error("Literal word not used as source one.");

   lane_masked_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      issue_valid && !exec_mask[0] |=> !result_lane_we[0] && $stable(result_data[31:0]))
      else $error("Disabled lane was written.");
endmodule

/* File: tb/issue_model.sv */
`timescale 1ns/1ps
module issue_model #(
   parameter int LANES = 4
) (
   // Clock.
   input wire logic sys_clk,
   // Instruction issue.
   output logic issue_valid,
   output logic [5:0] opcode,
   output logic ieee_mode,
   output logic three_src_form,
   // Extra word and float modifiers.
   output logic [1:0] extra_kind,
   output logic [31:0] extra_word,
   output logic [1:0] abs_mod,
   output logic [1:0] neg_mod,
   // Lane masks and operands.
   output logic [LANES-1:0] exec_mask,
   output logic [LANES-1:0] cond_mask,
   output logic [LANES-1:0] scalar_mask,
   output logic [LANES*32-1:0] src0,
   output logic [LANES*32-1:0] src1,
   output logic [LANES*32-1:0] dst_in
);
   // Idle at time zero.
   initial begin
      {issue_valid, opcode, ieee_mode, three_src_form} = '0;
      {extra_kind, extra_word, abs_mod, neg_mod} = '0;
      {exec_mask, cond_mask, scalar_mask, src0, src1, dst_in} = '0;
   end
   // One instruction for one edge; afterwards the stale operands are inverted.
   task automatic send(input logic [5:0] op, input logic ie, input logic th,
                       input logic [3*LANES-1:0] m, input logic [3*LANES*32-1:0] v,
                       input logic [37:0] x = '0);
      @(posedge sys_clk);
      issue_valid <= 1'b1;
      {extra_kind, extra_word, abs_mod, neg_mod} <= x;
      {opcode, ieee_mode, three_src_form} <= {op, ie, th};
      {exec_mask, cond_mask, scalar_mask} <= m;
      {src0, src1, dst_in} <= v;
      @(posedge sys_clk);
      issue_valid <= 1'b0;
      {exec_mask, cond_mask, scalar_mask} <= ~m;
      {src0, src1, dst_in} <= ~v;
   endtask
endmodule

/* File: tb/tb_vector_two_operand_alu.sv */
`timescale 1ns/1ps
module tb_vector_two_operand_alu;
   import valu_pkg::*;
   localparam int LANES = 4;
   logic sys_clk, rst_b, issue_valid, ieee_mode, three_src_form, result_valid, opcode_illegal;
   logic [5:0] opcode;
   logic [LANES-1:0] exec_mask, cond_mask, scalar_mask, result_lane_we;
   logic [LANES*32-1:0] src0, src1, dst_in, result_data;
   logic [31:0] prv [LANES];
   logic [1:0] abs_mod, neg_mod, extra_kind;
   logic [31:0] extra_word;
   logic [5:0] iop [10] = '{6'h01, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h11, 6'h12, 6'h13,
      6'h14};
   int error_cnt = 0;
   int checks_done = 0;
   integer seed = 32'h6eb9a964;
   // Float corner cases: opcode, mode, source one, source two, expected.
   logic [102:0] ftab [14] = '{
      {6'h02, 1'b0, 32'h3c003c00, 32'h40004000, 32'h40a00000},
      {6'h03, 1'b0, 32'h3f800000, 32'h3f800000, 32'h40000000},
      {6'h03, 1'b0, 32'h00000001, 32'h00000001, 32'h00000002},
      {6'h04, 1'b0, 32'h40000000, 32'h3f800000, 32'h3f800000},
      {6'h05, 1'b0, 32'h40000000, 32'h3f800000, 32'hbf800000},
      {6'h06, 1'b0, 32'h00000000, 32'h7fc00000, 32'h3f800000},
      {6'h07, 1'b0, 32'h00000000, 32'h7f800000, 32'h00000000},
      {6'h08, 1'b0, 32'h40000000, 32'h40400000, 32'h40c00000},
      {6'h0f, 1'b1, 32'h7f800001, 32'h3f800000, 32'h7fc00001},
      {6'h0f, 1'b1, 32'h7fc00000, 32'h3f800000, 32'h3f800000},
      {6'h0f, 1'b0, 32'h00000000, 32'h80000000, 32'h80000000},
      {6'h0f, 1'b0, 32'h3f800000, 32'h40000000, 32'h3f800000},
      {6'h10, 1'b1, 32'h3f800000, 32'hff800001, 32'hffc00001},
      {6'h10, 1'b0, 32'h80000000, 32'h00000000, 32'h00000000}};
   issue_model #(.LANES(LANES)) p (.sys_clk, .issue_valid, .opcode, .ieee_mode, .three_src_form,
      .extra_kind, .extra_word, .abs_mod, .neg_mod, .exec_mask, .cond_mask, .scalar_mask,
      .src0, .src1, .dst_in);
   vector_two_operand_alu #(.LANES(LANES)) uut (.sys_clk, .rst_b, .issue_valid, .opcode,
      .ieee_mode, .three_src_form, .abs_mod, .neg_mod, .extra_kind, .extra_word,
      .exec_mask, .cond_mask, .scalar_mask, .src0, .src1, .dst_in,
      .result_valid, .opcode_illegal, .result_lane_we, .result_data);
   // Clock of 5 ns.
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // Integer reference for one lane.
   function automatic logic [31:0] ref_op(input logic [5:0] op, input logic c,
                                          input logic [31:0] a, input logic [31:0] b,
                                          input logic [31:0] d);
      logic signed [47:0] sp;
      logic [47:0] up;
      logic signed [31:0] dot;
      sp = $signed(a[23:0]) * $signed(b[23:0]);
      up = a[23:0] * b[23:0];
      dot = d;
      for (int i = 0; i < 4; i++) begin
         dot += $signed(a[i*8+:8]) * $signed(b[i*8+:8]);
      end
      case (op)
         6'h01: return c ? b : a;
         6'h09: return sp[31:0];
         6'h0a: return {{16{sp[47]}}, sp[47:32]};
         6'h0b: return up[31:0];
         6'h0c: return {16'h0, up[47:32]};
         6'h0d: return dot;
         6'h11: return ($signed(a) < $signed(b)) ? a : b;
         6'h12: return ($signed(a) >= $signed(b)) ? a : b;
         6'h13: return (a < b) ? a : b;
         default: return (a >= b) ? a : b;
      endcase
   endfunction
   // Source one of a lane as the extra word defines it.
   function automatic logic [31:0] pick_a(input logic [1:0] k, input logic [31:0] w,
                                          input logic [LANES*32-1:0] s, input int l);
      logic [31:0] v;
      v = s[l*32+:32];
      case (k)
         2'h1: return w;
         2'h2: return s[((l & ~3) + w[2*(l%4)+:2])*32+:32];
         2'h3: return w[2] ? (w[1] ? v : {16'h0, v[w[0]*16+:16]})
                           : {24'h0, v[w[1:0]*8+:8]};
         default: return v;
      endcase
   endfunction
   // Reports and counts one comparison.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   // Compares write-back against the per-lane mirror.
   task automatic wb(input logic v, input logic [LANES-1:0] we);
      #1;
      chk(32'(result_valid), 32'(v));
      chk(32'(result_lane_we), 32'(we));
      foreach (prv[l]) chk(result_data[l*32+:32], prv[l]);
   endtask
   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Watchdog against a hang.
   initial begin
      #100000;
      error_cnt++;
      complete_run();
   end
   // Main sequence: reset, float corners, random integer traffic, illegal opcodes.
   initial begin
      rst_b = 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      foreach (prv[l]) prv[l] = RESULT_RESET;
      wb(1'b0, '0);
      foreach (ftab[i]) begin
         p.send(ftab[i][102:97], ftab[i][96], 1'b0, {{LANES{1'b1}}, {2*LANES{1'b0}}},
                {{LANES{ftab[i][95:64]}}, {LANES{ftab[i][63:32]}}, {LANES{32'h3f800000}}});
         foreach (prv[l]) prv[l] = ftab[i][31:0];
         wb(1'b1, '1);
      end
      $display("test float corners done");
      for (int i = 0; i < 60; i++) begin
         logic [LANES*32-1:0] a, b, d;
         logic [LANES-1:0] em, cm, sm;
         logic th;
         logic [37:0] x;
         logic [31:0] a_l, b_l;
         {em, cm, sm, th} = (3*LANES+1)'($random(seed));
         // Some steps pin lane 0 on so that the lane 0 checks in the design see traffic.
         if (i < 10 || i == 39) begin
            {em[0], sm[0], th} = 3'h7;
         end
         // From step 30 on, the extra word kind cycles and the modifiers are random.
         x = (i < 30) ? '0 : {2'(i % 3 + 1), 36'($random(seed))};
         for (int l = 0; l < LANES; l++) begin
            a[l*32+:32] = (i < 10) ? 32'h00800000 : $random(seed);
            b[l*32+:32] = $random(seed);
            d[l*32+:32] = $random(seed);
         end
         for (int l = 0; l < LANES; l++) begin
            a_l = pick_a(x[37:36], x[35:4], a, l);
            b_l = b[l*32+:32];
            if (iop[i%10] == 6'h01) begin
               {a_l[31], b_l[31]} = {a_l[31] & ~x[2] ^ x[0], b_l[31] & ~x[3] ^ x[1]};
            end
            if (em[l]) begin
               prv[l] = ref_op(iop[i%10], th ? sm[l] : cm[l], a_l, b_l, d[l*32+:32]);
            end
         end
         p.send(iop[i%10], th, th, {em, cm, sm}, {a, b, d}, x);
         wb(1'b1, em);
      end
      $display("test random integer done");
      // Reset again mid-run; every lane result must clear.
      @(posedge sys_clk) rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      foreach (prv[l]) prv[l] = RESULT_RESET;
      wb(1'b0, '0);
      $display("test mid-run reset done");
      foreach (iop[k]) begin
         p.send((k < 3) ? 6'h00 : (k < 6) ? 6'h0e : 6'h0f + 6'(k), 1'b0, 1'b0, '1, '1);
         #1 chk(32'(opcode_illegal), 32'h1);
         wb(1'b0, '0);
      end
      $display("test illegal opcode done");
      complete_run();
   end
endmodule
